// File: design/bemf_zero_crossing_detector.sv
// back-EMF / hall zero-crossing event detector with register port
`include "bemf_zero_regs.svh"

// Operation
// - sensorless sampling starts only once commutation then demag events occurred.
// - after C+D, and after Z, PWM group follows the output group select.
// - hardware crossing needs a programmed count of consecutive matching samples.
// - sample count is field plus one; simulated events bypass the filter.
// - high side group select picks the sensing group in sensorless mode only.
// - sensorless samples count only while PWM sits on the sensing group.
// - with capture enabled, timer is copied into capture register on crossing.
// - with simulation enabled, timer equal to capture register makes a crossing.
// - with both enabled, the first of hardware or simulated event wins.
// - a crossing sets the zero flag and requests interrupt when masked in.
// - after demag, capture at or below timer fires at once and reloads.
// - edge protection demands the previous sample held the opposite state.
// - without protection, consecutive samples equal to expected state suffice.
// - edge protection overrides the consecutive sample filter.
// - edge protection affects only hardware crossings in sensorless mode.
// - sensor mode uses one of three hall inputs chosen per step.
// - comparator stays off until clock enable or direct access is set.
// - sensor mode disables all demagnetisation handling.
// - sensor mode accepts crossings in any window at the sample rate.
// - sensor mode forces zero minimum off time and allows full duty.
// - consecutive sample filter stays active in sensor mode.
module bemf_zero_crossing_detector
#(
	parameter int TIMER_W = 16
)
(
	input  wire logic               ref_clk,
	input  wire logic               rst_n,
	input  wire logic [`ADDR_W-1:0] reg_addr,
	input  wire logic [TIMER_W-1:0] reg_wdata,
	input  wire logic               reg_wr,
	input  wire logic               reg_rd,
	output logic      [TIMER_W-1:0] reg_rdata,
	input  wire logic               commutation_evt,
	input  wire logic               demag_evt,
	input  wire logic [TIMER_W-1:0] motor_timer,
	input  wire logic               sample_strobe,
	input  wire logic               pwm_group_high,
	input  wire logic               phase_comp_in,
	input  wire logic               hall_input_a,
	input  wire logic               hall_input_b,
	input  wire logic               hall_input_c,
	output logic                    zero_cross_evt,
	output logic                    zero_cross_irq,
	output logic      [2:0]         pwm_group_sel,
	output logic                    comparator_on,
	output logic                    demag_enable,
	output logic                    min_off_zero,
	output logic                    full_duty_allow
);

	logic [3:0]         control_reg_a_q;
	logic [3:0]         control_reg_b_q;
	logic [1:0]         control_reg_c_q;
	logic [3:0]         zero_event_filter_q;
	logic [1:0]         polarity_reg_q;
	logic [1:0]         hall_input_select_q;
	logic [TIMER_W-1:0] zero_capture_q;
	logic               zero_cross_flag_q;
	logic               zero_cross_mask_q;
	logic [TIMER_W-1:0] reg_rdata_q;
	logic [2:0]         pwm_group_sel_q;
	logic               zero_cross_evt_q;
	logic               prev_sample_q;
	logic               prev_valid_q;
	bemf_zero_pkg::step_state_t state_q;
	bemf_zero_pkg::step_state_t state_d;

	logic               position_sensor_mode;
	logic               edge_protect;
	logic               clock_enable;
	logic               direct_access;
	logic [2:0]         output_group_select;
	logic               comparator_polarity;
	logic               hw_zero_capture_enable;
	logic               sim_zero_enable;
	logic               high_side_group_select;
	logic               edge_level_select;
	logic               hall_sel_in;
	logic               comparator_state;
	logic               expected_level;
	logic               sample_valid;
	logic               sample_match;
	logic               filter_hit;
	logic               protect_active;
	logic               zero_hw;
	logic               demag_check;
	logic               late_capture;
	logic               zero_sim;
	logic               zero_any;
	logic               demag_ok;
	logic               flag_wr_clear;

	// refused at elaboration: read port and compare need 8 to 32 bits
	if (TIMER_W < 8 || TIMER_W > 32)
	begin
		$error("bemf_zero_crossing_detector: TIMER_W out of range");
	end

	assign position_sensor_mode   = control_reg_a_q[`BIT_SENSOR_MODE];
	assign edge_protect           = control_reg_a_q[`BIT_EDGE_PROTECT];
	assign clock_enable           = control_reg_a_q[`BIT_CLOCK_ENABLE];
	assign direct_access          = control_reg_a_q[`BIT_DIRECT_ACCESS];
	assign output_group_select    = control_reg_b_q[`FLD_GROUP_SEL_HI:0];
	assign comparator_polarity    = control_reg_b_q[`BIT_COMP_POLARITY];
	assign hw_zero_capture_enable = control_reg_c_q[`BIT_HW_CAPTURE];
	assign sim_zero_enable        = control_reg_c_q[`BIT_SIM_ZERO];
	assign high_side_group_select = polarity_reg_q[`BIT_HIGH_SIDE_SEL];
	assign edge_level_select      = polarity_reg_q[`BIT_EDGE_LEVEL_SEL];

	// hall input chosen for this step; code 3 falls back to input a
	always_comb
	begin
		unique case (hall_input_select_q)
			2'h1:    hall_sel_in = hall_input_b;
			2'h2:    hall_sel_in = hall_input_c;
			default: hall_sel_in = hall_input_a;
		endcase
	end

	// a switched-off comparator reads as zero, so no sample can match high
	assign comparator_on    = clock_enable | direct_access;
	assign comparator_state = comparator_on
		& (position_sensor_mode ? hall_sel_in : phase_comp_in);

	// with edge level select 0, polarity 0 expects a rising edge (high), 1 a falling edge (low); select 1 inverts
	assign expected_level = ~(comparator_polarity ^ edge_level_select);

	assign demag_enable    = ~position_sensor_mode;
	assign min_off_zero    = position_sensor_mode;
	assign full_duty_allow = position_sensor_mode;
	assign demag_ok        = demag_evt && !position_sensor_mode;

	// sensor mode samples in any window; sensorless only on the sensing group
	assign sample_valid = (state_q == bemf_zero_pkg::ST_SAMPLING)
		&& clock_enable && sample_strobe
		&& (position_sensor_mode
		|| (pwm_group_high == high_side_group_select));
	assign sample_match = (comparator_state == expected_level);

	assign protect_active = edge_protect && !position_sensor_mode;

	consec_sample_filter
	#(
		.CNT_W (4)
	)
	u_filter
	(
		.ref_clk      (ref_clk),
		.rst_n        (rst_n),
		.clear        (state_q != bemf_zero_pkg::ST_SAMPLING),
		.sample_valid (sample_valid && !protect_active),
		.sample_match (sample_match),
		.limit        (zero_event_filter_q),
		.hit          (filter_hit)
	);

	// protected detection needs the previous sample, taken since arming
	assign zero_hw = protect_active
		? (sample_valid && sample_match && prev_valid_q
		&& (prev_sample_q != comparator_state))
		: filter_hit;

	// late value check right after demag: fire at once and reload
	assign demag_check  = demag_ok && sim_zero_enable
		&& (state_q == bemf_zero_pkg::ST_WAIT_DEMAG);
	assign late_capture = demag_check && (zero_capture_q <= motor_timer);
	assign zero_sim = late_capture
		|| (sim_zero_enable && (state_q == bemf_zero_pkg::ST_SAMPLING)
		&& (motor_timer == zero_capture_q));

	// first event of either kind ends the step
	assign zero_any = zero_hw || zero_sim;

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n || !sample_valid)
		begin
			if (!rst_n || state_q != bemf_zero_pkg::ST_SAMPLING)
			begin
				prev_valid_q  <= 1'b0;
				prev_sample_q <= 1'b0;
			end
		end
		else
		begin
			prev_valid_q  <= 1'b1;
			prev_sample_q <= comparator_state;
		end
	end

	always_comb
	begin
		state_d = state_q;
		unique case (state_q)
			bemf_zero_pkg::ST_WAIT_COMMUT:
			begin
				if (commutation_evt)
					state_d = position_sensor_mode
						? bemf_zero_pkg::ST_SAMPLING
						: bemf_zero_pkg::ST_WAIT_DEMAG;
			end
			bemf_zero_pkg::ST_WAIT_DEMAG:
			begin
				if (commutation_evt)
					state_d = state_q;
				else if (late_capture)
					state_d = bemf_zero_pkg::ST_WAIT_COMMUT;
				else if (demag_ok || position_sensor_mode)
					state_d = bemf_zero_pkg::ST_SAMPLING;
			end
			bemf_zero_pkg::ST_SAMPLING:
			begin
				if (commutation_evt)
					state_d = position_sensor_mode
						? bemf_zero_pkg::ST_SAMPLING
						: bemf_zero_pkg::ST_WAIT_DEMAG;
				else if (zero_any)
					state_d = bemf_zero_pkg::ST_WAIT_COMMUT;
			end
			default:
				state_d = bemf_zero_pkg::ST_WAIT_COMMUT;
		endcase
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			state_q <= bemf_zero_pkg::ST_WAIT_COMMUT;
		else
			state_q <= state_d;
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			zero_cross_evt_q <= 1'b0;
		else
			zero_cross_evt_q <= zero_any && !commutation_evt;
	end

	// group switch on entering sampling and again after the crossing
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			pwm_group_sel_q <= 3'h0;
		else if ((state_q != bemf_zero_pkg::ST_SAMPLING
			&& state_d == bemf_zero_pkg::ST_SAMPLING)
			|| (zero_any && !commutation_evt))
			pwm_group_sel_q <= output_group_select;
	end

	// capture and reload win over a software write in the same cycle
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			zero_capture_q <= '0;
		else if (late_capture)
			zero_capture_q <= motor_timer;
		else if (zero_hw && hw_zero_capture_enable && !commutation_evt)
			zero_capture_q <= motor_timer;
		else if (reg_wr && reg_addr == `OFS_ZERO_CAPTURE_REG)
			zero_capture_q <= reg_wdata;
	end

	// write one to clear; a new crossing in the same cycle keeps it set
	assign flag_wr_clear = reg_wr && reg_addr == `OFS_IRQ_STATUS_REG
		&& reg_wdata[`BIT_ZERO_FLAG];

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			zero_cross_flag_q <= 1'b0;
		else if (zero_cross_evt_q)
			zero_cross_flag_q <= 1'b1;
		else if (flag_wr_clear)
			zero_cross_flag_q <= 1'b0;
	end

	assign zero_cross_irq = zero_cross_flag_q && zero_cross_mask_q;

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			control_reg_a_q     <= `RST_CONTROL_REG_A;
			control_reg_b_q     <= `RST_CONTROL_REG_B;
			control_reg_c_q     <= `RST_CONTROL_REG_C;
			zero_event_filter_q <= `RST_ZERO_FILTER;
			polarity_reg_q      <= `RST_POLARITY_REG;
			hall_input_select_q <= `RST_HALL_SEL;
			zero_cross_mask_q   <= 1'b0;
		end
		else if (reg_wr)
		begin
			unique case (reg_addr)
				`OFS_CONTROL_REG_A:
					control_reg_a_q <= reg_wdata[3:0];
				`OFS_CONTROL_REG_B:
					control_reg_b_q <= reg_wdata[3:0];
				`OFS_CONTROL_REG_C:
					control_reg_c_q <= reg_wdata[1:0];
				`OFS_ZERO_FILTER_REG:
					zero_event_filter_q <= reg_wdata[`FLD_ZEF_HI:0];
				`OFS_POLARITY_REG:
					polarity_reg_q <= reg_wdata[1:0];
				`OFS_PHASE_STATE_REG:
					hall_input_select_q <= reg_wdata[`FLD_HALL_SEL_HI:0];
				`OFS_IRQ_MASK_REG:
					zero_cross_mask_q <= reg_wdata[`BIT_ZERO_MASK];
				default:
				begin
				end
			endcase
		end
	end

	// read data valid only in the cycle after the strobe; unmapped reads zero
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n || !reg_rd)
			reg_rdata_q <= '0;
		else
		begin
			unique case (reg_addr)
				`OFS_CONTROL_REG_A:
					reg_rdata_q <= TIMER_W'(control_reg_a_q);
				`OFS_CONTROL_REG_B:
					reg_rdata_q <= TIMER_W'(control_reg_b_q);
				`OFS_CONTROL_REG_C:
					reg_rdata_q <= TIMER_W'(control_reg_c_q);
				`OFS_ZERO_FILTER_REG:
					reg_rdata_q <= TIMER_W'(zero_event_filter_q);
				`OFS_POLARITY_REG:
					reg_rdata_q <= TIMER_W'(polarity_reg_q);
				`OFS_PHASE_STATE_REG:
					reg_rdata_q <= TIMER_W'(hall_input_select_q);
				`OFS_ZERO_CAPTURE_REG:
					reg_rdata_q <= zero_capture_q;
				`OFS_IRQ_STATUS_REG:
					reg_rdata_q <= TIMER_W'({
						state_q == bemf_zero_pkg::ST_SAMPLING,
						state_q == bemf_zero_pkg::ST_WAIT_DEMAG,
						zero_cross_flag_q});
				`OFS_IRQ_MASK_REG:
					reg_rdata_q <= TIMER_W'(zero_cross_mask_q);
				`OFS_REFERENCE_REG:
					reg_rdata_q <= TIMER_W'(comparator_state);
				default:
					reg_rdata_q <= '0;
			endcase
		end
	end

	assign reg_rdata      = reg_rdata_q;
	assign zero_cross_evt = zero_cross_evt_q;
	assign pwm_group_sel  = pwm_group_sel_q;

endmodule

// File: design/bemf_zero_regs.svh
// register offsets, field positions and reset values of the zero-crossing block
`ifndef BEMF_ZERO_REGS_SVH
`define BEMF_ZERO_REGS_SVH

`define ADDR_W                  8
`define OFS_CONTROL_REG_A       8'h00
`define OFS_CONTROL_REG_B       8'h04
`define OFS_CONTROL_REG_C       8'h08
`define OFS_ZERO_FILTER_REG     8'h0C
`define OFS_POLARITY_REG        8'h10
`define OFS_PHASE_STATE_REG     8'h14
`define OFS_ZERO_CAPTURE_REG    8'h18
`define OFS_IRQ_STATUS_REG      8'h1C
`define OFS_IRQ_MASK_REG        8'h20
`define OFS_REFERENCE_REG       8'h24

`define BIT_SENSOR_MODE         0
`define BIT_EDGE_PROTECT        1
`define BIT_CLOCK_ENABLE        2
`define BIT_DIRECT_ACCESS       3
`define FLD_GROUP_SEL_HI        2
`define BIT_COMP_POLARITY       3
`define BIT_HW_CAPTURE          0
`define BIT_SIM_ZERO            1
`define FLD_ZEF_HI              3
`define BIT_HIGH_SIDE_SEL       0
`define BIT_EDGE_LEVEL_SEL      1
`define FLD_HALL_SEL_HI         1
`define BIT_ZERO_FLAG           0
`define BIT_WAIT_DEMAG          1
`define BIT_SAMPLING            2
`define BIT_ZERO_MASK           0
`define BIT_COMP_STATE          0

`define RST_CONTROL_REG_A       4'h0
`define RST_CONTROL_REG_B       4'h0
`define RST_CONTROL_REG_C       2'h0
`define RST_ZERO_FILTER         4'h0
`define RST_POLARITY_REG        2'h0
`define RST_HALL_SEL            2'h0
`define MIN_OFF_SENSOR_US       0

`endif

// File: design/bemf_zero_pkg.sv
// types shared by the zero-crossing detector
package bemf_zero_pkg;

	typedef enum logic [2:0]
	{
		ST_WAIT_COMMUT = 3'b001,
		ST_WAIT_DEMAG  = 3'b010,
		ST_SAMPLING    = 3'b100
	} step_state_t;

endpackage

// File: design/consec_sample_filter.sv
// counts consecutive matching samples up to a programmable limit
module consec_sample_filter
#(
	parameter int CNT_W = 4
)
(
	input  wire logic             ref_clk,
	input  wire logic             rst_n,
	input  wire logic             clear,
	input  wire logic             sample_valid,
	input  wire logic             sample_match,
	input  wire logic [CNT_W-1:0] limit,
	output logic                  hit
);

	logic [CNT_W-1:0] count_q;

	// refused at elaboration: the count compare is kept narrow
	if (CNT_W < 1 || CNT_W > 8)
	begin
		$error("consec_sample_filter: CNT_W out of range");
	end

	// limit holds the count minus one, so a field of zero needs one sample
	assign hit = sample_valid && sample_match && (count_q == limit);

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n || clear)
			count_q <= '0;
		else if (sample_valid)
		begin
			if (!sample_match || hit)
				count_q <= '0;
			else
				count_q <= count_q + CNT_W'(1);
		end
	end

endmodule

// File: bench/bemf_zero_assertions.sv
// port-level assertions of the zero-crossing detector
`include "bemf_zero_regs.svh"
module bemf_zero_checker
#(
	parameter int TIMER_W = 16
)
(
	input wire logic               ref_clk,
	input wire logic               rst_n,
	input wire logic [`ADDR_W-1:0] reg_addr,
	input wire logic [TIMER_W-1:0] reg_wdata,
	input wire logic               reg_wr,
	input wire logic               commutation_evt,
	input wire logic               demag_evt,
	input wire logic               zero_cross_evt,
	input wire logic               zero_cross_irq,
	input wire logic [2:0]         pwm_group_sel,
	input wire logic               comparator_on,
	input wire logic               demag_enable,
	input wire logic               min_off_zero,
	input wire logic               full_duty_allow
);
	timeunit 1ns;
	timeprecision 1ns;
	logic       sens_q, mask_q, dseen_q;
	logic [2:0] os_q;
	wire        wa = reg_wr && reg_addr == `OFS_CONTROL_REG_A;
	wire        wm = reg_wr && reg_addr == `OFS_IRQ_MASK_REG;
	wire        ws = reg_wr && reg_addr == `OFS_IRQ_STATUS_REG;
	// shadows of the few control bits that the outputs depend on
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			sens_q  <= 1'b0;
			mask_q  <= 1'b0;
			dseen_q <= 1'b0;
			os_q    <= 3'h0;
		end
		else
		begin
			if (wa)
				sens_q <= reg_wdata[`BIT_SENSOR_MODE];
			if (wm)
				mask_q <= reg_wdata[`BIT_ZERO_MASK];
			if (reg_wr && reg_addr == `OFS_CONTROL_REG_B)
				os_q <= reg_wdata[2:0];
			if (commutation_evt)
				dseen_q <= 1'b0;
			else if (demag_evt)
				dseen_q <= 1'b1;
		end
	end
	default clocking dc @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	a_comp_on_cause: assert property (
		$changed(comparator_on) |-> $past(wa))
		else $error("comparator enable changed without a control write");
	a_sensor_outputs: assert property (
		demag_enable == !sens_q && min_off_zero == sens_q
		&& full_duty_allow == sens_q)
		else $error("sensor mode outputs disagree with control bit");
	a_evt_after_demag: assert property (
		zero_cross_evt && !sens_q |-> dseen_q)
		else $error("sensorless crossing before demag event");
	a_commut_drops: assert property (
		commutation_evt |=> !zero_cross_evt)
		else $error("crossing reported beside a commutation");
	a_evt_single: assert property (
		zero_cross_evt |=> !zero_cross_evt)
		else $error("two crossings in one step");
	a_group_on_z: assert property (
		zero_cross_evt |-> pwm_group_sel == $past(os_q))
		else $error("output group not applied at crossing");
	a_irq_follows: assert property (
		zero_cross_evt && mask_q && !wm |=> zero_cross_irq)
		else $error("masked-in crossing raised no interrupt");
	a_irq_holds: assert property (
		zero_cross_irq && !wm && !ws |=> zero_cross_irq)
		else $error("interrupt dropped without a clear");
	a_irq_cause: assert property (
		$rose(zero_cross_irq) |-> $past(zero_cross_evt) || $past(wm))
		else $error("interrupt rose without a crossing");
	c_hw: cover property (zero_cross_evt && !sens_q);
	c_sensor: cover property (zero_cross_evt && sens_q);
	c_irq: cover property ($rose(zero_cross_irq));
endmodule

bind bemf_zero_crossing_detector bemf_zero_checker #(.TIMER_W(TIMER_W)) chk (.*);

// File: bench/bemf_motor_model.sv
// behavioural model of the phase comparator and the hall sensors
module bemf_motor_model
(
	input  wire logic       ref_clk,
	input  wire logic       bemf,
	input  wire logic       slow,
	input  wire logic [2:0] hall,
	output logic            phase_comp_in = 1'b0,
	output logic            hall_input_a = 1'b0,
	output logic            hall_input_b = 1'b0,
	output logic            hall_input_c = 1'b0
);
	timeunit 1ns;
	timeprecision 1ns;
	logic lag_q = 1'b0;
	// a slow comparator settles one cycle later than a prompt one
	always @(posedge ref_clk)
	begin
		lag_q <= bemf;
		phase_comp_in <= slow ? lag_q : bemf;
		{hall_input_c, hall_input_b, hall_input_a} <= hall;
	end
endmodule

// File: bench/bemf_zero_crossing_detector_bench.sv
// self-checking bench of the zero-crossing detector
`include "bemf_zero_regs.svh"
module bemf_zero_crossing_detector_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic        ref_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [7:0]  reg_addr = 8'h00;
	logic [15:0] reg_wdata = 16'h0000;
	logic [15:0] motor_timer = 16'h0000;
	logic [15:0] evt_count = 16'h0000;
	logic [15:0] lf = 16'h0028;
	logic [15:0] reg_rdata, exp_cap, rv, v, n;
	logic        commutation_evt = 1'b0;
	logic        demag_evt = 1'b0;
	logic        sample_strobe = 1'b0;
	logic        pwm_group_high = 1'b0;
	logic        bemf = 1'b0;
	logic        slow = 1'b0;
	logic [2:0]  hall = 3'h0;
	logic [2:0]  os, pwm_group_sel;
	logic        pe, phase_comp_in, hall_input_a, hall_input_b, hall_input_c;
	logic        zero_cross_evt, zero_cross_irq, comparator_on;
	logic        demag_enable, min_off_zero, full_duty_allow;
	int          fail_count = 0;
	int          n_checks = 0;
	int          cyc = 0;
	int          f, i;
	bemf_zero_crossing_detector #(.TIMER_W(16)) dut (.*);
	bemf_motor_model model (.*);
	always #20 ref_clk = ~ref_clk;
	always @(posedge ref_clk)
	begin
		motor_timer <= motor_timer + 16'h1;
		cyc <= cyc + 1;
		// the crossing was detected one edge before it is seen here
		if (zero_cross_evt === 1'b1)
		begin
			evt_count <= evt_count + 16'h1;
			exp_cap <= motor_timer - 16'h1;
		end
		if (cyc == 20000)
		begin
			fail_count++;
			stop_test();
		end
	end
	function automatic logic [15:0] nx(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic int idx(input int s);
		return (s == 3) ? 0 : s;
	endfunction
	function automatic logic lvl(input logic p, input logic l);
		return ~(p ^ l);
	endfunction
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
		@(posedge ref_clk);
	endtask
	task automatic ev(input logic [1:0] k);
		{demag_evt, commutation_evt} <= k;
		@(posedge ref_clk);
		{demag_evt, commutation_evt} <= 2'b00;
		@(posedge ref_clk);
	endtask
	task automatic smp(input logic b, input logic g);
		lf = nx(lf);
		bemf <= b;
		slow <= lf[0];
		pwm_group_high <= g;
		repeat (4) @(posedge ref_clk);
		sample_strobe <= 1'b1;
		@(posedge ref_clk);
		sample_strobe <= 1'b0;
		repeat (2) @(posedge ref_clk);
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial
	begin
		repeat (8) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		chk({comparator_on, demag_enable, min_off_zero,
			full_duty_allow}, 4'h4);
		wr(8'h28, 16'hFFFF);
		for (i = 0; i <= 'h28; i += 4)
		begin
			rd(i[7:0], rv);
			chk(rv, 16'h0000);
		end
		for (i = 0; i < 3; i++)
		begin
			wr(`OFS_CONTROL_REG_A, 16'(4 << i) & 16'h000C);
			chk(comparator_on, i < 2);
		end
		$display("reset and enable test ended");
		wr(`OFS_IRQ_MASK_REG, 16'h0001);
		for (i = 0; i < 4; i++)
		begin
			lf = nx(lf);
			f = (i == 3) ? 15 : lf[1:0];
			os = lf[4:2];
			pe = lvl(i[0], i[1]);
			n = evt_count;
			wr(`OFS_CONTROL_REG_A, 16'h0004);
			wr(`OFS_CONTROL_REG_B, 16'({i[0], os}));
			wr(`OFS_ZERO_FILTER_REG, 16'(f));
			wr(`OFS_POLARITY_REG, 16'({i[1], 1'b1}));
			ev(2'b01);
			rd(`OFS_IRQ_STATUS_REG, rv);
			chk(rv, 16'h0002);
			smp(pe, 1'b1);
			ev(2'b10);
			rd(`OFS_IRQ_STATUS_REG, rv);
			chk(rv, 16'h0004);
			smp(pe, 1'b0);
			repeat (f) smp(pe, 1'b1);
			smp(!pe, 1'b1);
			repeat (f) smp(pe, 1'b1);
			chk(evt_count, n);
			smp(pe, 1'b1);
			chk(evt_count, n + 16'h1);
			chk(pwm_group_sel, os);
			rd(`OFS_IRQ_STATUS_REG, rv);
			chk(rv[0] & zero_cross_irq, 1'b1);
			wr(`OFS_IRQ_STATUS_REG, 16'h0001);
			chk(zero_cross_irq, 1'b0);
		end
		$display("filter test ended");
		n = evt_count;
		wr(`OFS_CONTROL_REG_A, 16'h0006);
		wr(`OFS_ZERO_FILTER_REG, 16'h000F);
		wr(`OFS_CONTROL_REG_B, 16'h0000);
		wr(`OFS_POLARITY_REG, 16'h0001);
		ev(2'b01);
		ev(2'b10);
		smp(1'b1, 1'b1);
		smp(1'b0, 1'b1);
		chk(evt_count, n);
		smp(1'b1, 1'b1);
		chk(evt_count, n + 16'h1);
		$display("edge protection test ended");
		wr(`OFS_CONTROL_REG_A, 16'h0004);
		wr(`OFS_CONTROL_REG_C, 16'h0003);
		wr(`OFS_ZERO_FILTER_REG, 16'h0000);
		wr(`OFS_ZERO_CAPTURE_REG, motor_timer + 16'd300);
		n = evt_count;
		ev(2'b01);
		ev(2'b10);
		smp(1'b1, 1'b1);
		rd(`OFS_ZERO_CAPTURE_REG, rv);
		chk(rv, exp_cap);
		repeat (400) @(posedge ref_clk);
		chk(evt_count, n + 16'h1);
		v = motor_timer + 16'd60;
		wr(`OFS_CONTROL_REG_A, 16'h0006);
		wr(`OFS_CONTROL_REG_C, 16'h0002);
		wr(`OFS_ZERO_CAPTURE_REG, v);
		n = evt_count;
		ev(2'b01);
		ev(2'b10);
		repeat (80) @(posedge ref_clk);
		chk(evt_count, n + 16'h1);
		chk(exp_cap, v);
		wr(`OFS_ZERO_CAPTURE_REG, motor_timer);
		n = evt_count;
		ev(2'b01);
		ev(2'b10);
		@(posedge ref_clk);
		chk(evt_count, n + 16'h1);
		rd(`OFS_ZERO_CAPTURE_REG, rv);
		chk(rv, exp_cap);
		chk(zero_cross_irq, 1'b1);
		wr(`OFS_IRQ_MASK_REG, 16'h0000);
		chk(zero_cross_irq, 1'b0);
		$display("capture and simulated test ended");
		wr(`OFS_CONTROL_REG_C, 16'h0000);
		wr(`OFS_CONTROL_REG_A, 16'h0005);
		wr(`OFS_ZERO_FILTER_REG, 16'h0001);
		chk({demag_enable, min_off_zero, full_duty_allow}, 3'b011);
		for (i = 0; i < 4; i++)
		begin
			hall <= 3'b001 << idx(i);
			wr(`OFS_PHASE_STATE_REG, 16'(i));
			n = evt_count;
			ev(2'b01);
			smp(1'b0, 1'b0);
			chk(evt_count, n);
			smp(1'b0, 1'b0);
			chk(evt_count, n + 16'h1);
		end
		wr(`OFS_CONTROL_REG_A, 16'h0009);
		for (i = 0; i < 4; i++)
		begin
			lf = nx(lf);
			hall <= lf[2:0];
			wr(`OFS_PHASE_STATE_REG, 16'(i));
			rd(`OFS_REFERENCE_REG, rv);
			chk(rv, lf[idx(i)]);
		end
		wr(`OFS_CONTROL_REG_A, 16'h0001);
		rd(`OFS_REFERENCE_REG, rv);
		chk(rv, 16'h0000);
		$display("sensor mode test ended");
		stop_test();
	end
endmodule
